// file: rtl/dcrs_map.svh
// Offsets, field positions, codes and timing counts of the result status block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DCRS_MAP_SVH
`define DCRS_MAP_SVH

// APB byte addresses
`define DCRS_OFS_FIRST     12'h000
`define DCRS_OFS_SECOND    12'h004
`define DCRS_OFS_CTRL      12'h008
`define DCRS_OFS_STATE     12'h00C

// First status byte fields
`define DCRS_F_TC_HI       7
`define DCRS_F_TC_LO       6
`define DCRS_F_SEEK        5
`define DCRS_F_EQUIP       4
`define DCRS_F_NRDY        3
`define DCRS_F_HEAD        2

// Second status byte fields
`define DCRS_S_EOC         7
`define DCRS_S_CRC         5
`define DCRS_S_OVR         4
`define DCRS_S_MISS        2

// Termination codes
`define DCRS_TC_NORMAL     2'h0
`define DCRS_TC_ABNORMAL   2'h1
`define DCRS_TC_INVALID    2'h2
`define DCRS_TC_READY      2'h3

// Invalid command first byte
`define DCRS_INVALID_BYTE  8'h80

// Retraction step limit
`define DCRS_STEP_LIMIT    7'h4D

// Byte service windows in ns, and their cycle counts at 50 ns
`define DCRS_CLK_NS        50
`define DCRS_SVC_FM_NS     27000
`define DCRS_SVC_MFM_NS    13000
`define DCRS_SVC_FM_CYC    (`DCRS_SVC_FM_NS / `DCRS_CLK_NS)
`define DCRS_SVC_MFM_CYC   (`DCRS_SVC_MFM_NS / `DCRS_CLK_NS)

// Reset values
`define DCRS_RST_BYTE      8'h00
`define DCRS_RST_WORD      32'h0000_0000

`endif

// file: rtl/dcrs_pkg.sv
// Types shared by the result status block.
// Assumes the constant header is on the include path.
`include "dcrs_map.svh"

package dcrs_pkg;

	// Command classes driving flag selection
	typedef enum logic [2:0] {
		DCRS_CMD_OTHER,
		DCRS_CMD_READ,
		DCRS_CMD_WRITE,
		DCRS_CMD_READ_ID,
		DCRS_CMD_READ_TRACK,
		DCRS_CMD_POSITION,
		DCRS_CMD_RETRACT,
		DCRS_CMD_SENSE
	} dcrs_cmd_t;

	// Sequencer events, one-cycle pulses
	typedef struct packed {
		logic start;         // Command starts execution
		logic done_ok;       // Command finished properly
		logic done_bad;      // Command ended abnormally
		logic undefined;     // Undefined command issued
		logic position_done; // Head positioning reached target
		logic step_pulse;    // Step pulse issued
		logic eoc;           // Sector past end of cylinder
		logic crc_fail;      // ID or data CRC failed
		logic id_not_found;  // Requested sector identifier not located
		logic byte_req;      // Data byte awaits service
		logic byte_ack;      // Data byte serviced
	} dcrs_evt_t;

	// Drive status lines
	typedef struct packed {
		logic ready;       // Drive ready
		logic fault;       // Drive fault
		logic track_zero;  // Head at track zero
		logic two_sided;   // Drive is double sided
	} dcrs_drv_t;

	// Selection at interrupt
	typedef struct packed {
		logic       head_side;
		logic [1:0] unit_sel;
	} dcrs_sel_t;

	// Controller state
	typedef enum logic [1:0] {
		DCRS_IDLE,
		DCRS_EXEC,
		DCRS_RESULT
	} dcrs_state_t;

endpackage

// file: rtl/dcrs_status.sv
// Result status composition for a disk controller, with an APB register slave.
// Assumes sequencer events are one-cycle pulses on CLK; drive lines are asynchronous pins.
// Assumes one command at a time; parallel positioning of several drives is not modelled.
// Assumes the host reads the first byte last, since that read ends the result phase.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "dcrs_map.svh"

module dcrs_status #(
	parameter int SVC_FM_CYC  = `DCRS_SVC_FM_CYC,
	parameter int SVC_MFM_CYC = `DCRS_SVC_MFM_CYC
) (
	input  wire logic                CLK,
	input  wire logic                NRST,
	input  wire logic [11:0]         PADDR,
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [31:0]         PWDATA,
	output logic      [31:0]         PRDATA,
	output logic                     PREADY,
	output logic                     PSLVERR,
	input  wire dcrs_pkg::dcrs_cmd_t CMD,
	input  wire dcrs_pkg::dcrs_evt_t EVT,
	input  wire dcrs_pkg::dcrs_sel_t SEL,
	input  wire dcrs_pkg::dcrs_drv_t DRV,
	output logic                     INT_REQ,
	output logic                     RESULT_READY,
	output logic                     CMD_ABORT
);
	import dcrs_pkg::*;

	// Drive line synchronisers
	// The pins move at any time, so only the second stage reads the first
	dcrs_drv_t   drv_s1_r;            // First stage, read only by second
	dcrs_drv_t   drv_r;               // Synchronised drive lines
	logic        rdy_prev_r;          // Ready delayed for change detect
	logic        rdy_chg;             // Ready changed during execution
	logic        rdy_idle_chg;        // Ready changed while idle
	logic [1:0]  fill_r;              // Edges since reset, saturating at three
	logic        rdy_primed;          // Stages and delayed copy hold pin values

	// Working state
	dcrs_state_t state_r;             // Controller phase
	dcrs_cmd_t   cmd_r;               // Command being executed
	logic        double_den_r;        // Density select from control reg
	logic [6:0]  step_cnt_r;          // Steps during retraction
	logic [9:0]  svc_cnt_r;           // Byte service timer, wide enough for FM
	logic        svc_wait_r;          // Byte pending
	logic        ovr_evt;             // Service window expired

	// Working flags gathered during execution
	// Folded into the result bytes on the termination edge
	logic        eoc_w_r;             // Sector past end of cylinder seen
	logic        crc_w_r;             // CRC failure seen
	logic        ovr_w_r;             // Late byte service seen
	logic        miss_w_r;            // Sector identifier not located
	logic        equip_w_r;           // Fault or failed retraction
	logic        nrdy_w_r;            // Not ready at start

	// Latched result bytes
	logic [7:0]  first_r;
	logic [7:0]  second_r;
	logic [7:0]  first_nxt;
	logic [7:0]  second_nxt;
	logic [1:0]  tc_nxt;
	logic        finish;              // Termination in this cycle
	logic        pos_cmd;             // Positioning or retraction command
	logic        rw_cmd;              // Read or write class command
	logic        retract_fail;        // 77 steps without track zero
	logic        nrdy_start;          // Not-ready condition at start

	// APB access strobes
	logic        apb_wr;              // Access phase of a write
	logic        apb_rd;              // Access phase of a read
	logic        leave_res;           // Host read that ends the result phase

	// Bus strobes of the access phase
	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign apb_rd = PSEL && PENABLE && !PWRITE;
	assign leave_res = (state_r == DCRS_RESULT) && apb_rd && (PADDR == `DCRS_OFS_FIRST);

	// Command classes
	assign pos_cmd = (cmd_r == DCRS_CMD_POSITION) || (cmd_r == DCRS_CMD_RETRACT);
	assign rw_cmd = (CMD == DCRS_CMD_READ) || (CMD == DCRS_CMD_WRITE) ||
		(CMD == DCRS_CMD_READ_ID) || (CMD == DCRS_CMD_READ_TRACK);

	// A ready edge counts only once the stages hold pin values,
	// so the stages filling after reset raise no false change
	assign rdy_primed = (fill_r == 2'h3);
	assign rdy_chg = (state_r == DCRS_EXEC) && rdy_primed && (drv_r.ready != rdy_prev_r);
	assign rdy_idle_chg = (state_r == DCRS_IDLE) && rdy_primed &&
		(drv_r.ready != rdy_prev_r);

	// The 77th step pulse with the head still off track zero
	assign retract_fail = (cmd_r == DCRS_CMD_RETRACT) && EVT.step_pulse &&
		!drv_r.track_zero && (step_cnt_r == (`DCRS_STEP_LIMIT - 7'h01));

	// Drive not ready, or side 1 asked of a single sided drive
	assign nrdy_start = !drv_r.ready || (SEL.head_side && !drv_r.two_sided);

	// Service window ran out with the byte still waiting
	assign ovr_evt = svc_wait_r && !EVT.byte_ack && (svc_cnt_r == 10'h000);

	// Every way that execution can end in this cycle
	assign finish = (state_r == DCRS_EXEC) && (EVT.done_ok || EVT.done_bad ||
		EVT.position_done || rdy_chg || retract_fail || ovr_evt || nrdy_w_r);

	// Two-stage synchroniser for drive lines
	// Drive-line causes therefore act two edges after the pin moves;
	// the delayed ready copy feeds the change detector
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			drv_s1_r   <= '0;
			drv_r      <= '0;
			rdy_prev_r <= 1'b0;
		end else begin
			drv_s1_r   <= DRV;
			drv_r      <= drv_s1_r;
			rdy_prev_r <= drv_r.ready;
		end
	end

	// Fill count after reset
	// Three edges fill both stages and the delayed ready copy
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			fill_r <= 2'h0;
		end else if (fill_r != 2'h3) begin
			fill_r <= fill_r + 2'h1; // Saturates once primed
		end
	end

	// Phase tracking and command capture
	// An undefined command never executes: it goes straight to the result
	// phase, with no interrupt. A start is taken only while idle; one that
	// arrives in another phase is ignored. The result phase ends only by
	// the host's read of the first byte.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_r <= DCRS_IDLE;
			cmd_r   <= DCRS_CMD_OTHER;
		end else begin
			case (state_r)
				DCRS_IDLE: begin
					if (EVT.undefined) begin
						state_r <= DCRS_RESULT;
					end else if (EVT.start) begin
						state_r <= DCRS_EXEC;
						cmd_r   <= CMD;
					end
				end
				DCRS_EXEC: begin
					if (finish) begin
						state_r <= DCRS_RESULT;
					end
				end
				default: begin
					// Held until host reads the first byte
					if (leave_res) begin
						state_r <= DCRS_IDLE;
					end
				end
			endcase
		end
	end

	// Step counter during retraction
	// Cleared outside execution, so every retraction counts from zero;
	// seven bits hold the full step limit
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			step_cnt_r <= 7'h00;
		end else if (state_r != DCRS_EXEC) begin
			step_cnt_r <= 7'h00;
		end else if (EVT.step_pulse && cmd_r == DCRS_CMD_RETRACT) begin
			step_cnt_r <= step_cnt_r + 7'h01;
		end
	end

	// Byte service window timer
	// Loaded on a byte request, counts down while the byte waits;
	// an acknowledge in the expiry cycle still counts as in time.
	// Density comes from the control register at the request.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			svc_cnt_r  <= 10'h000;
			svc_wait_r <= 1'b0;
		end else if (state_r != DCRS_EXEC || EVT.byte_ack) begin
			svc_wait_r <= 1'b0;
		end else if (EVT.byte_req) begin
			svc_wait_r <= 1'b1;
			svc_cnt_r  <= double_den_r ? 10'(SVC_MFM_CYC - 1) : 10'(SVC_FM_CYC - 1);
		end else if (svc_wait_r && svc_cnt_r != 10'h000) begin
			svc_cnt_r <= svc_cnt_r - 10'h001;
		end
	end

	// Working flags, cleared at start, set by events
	// Not-ready and fault are judged on the synchronised lines at start;
	// fault is also watched through execution. Flags stay set until the
	// next start, so a late event cannot clear an earlier one.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			eoc_w_r   <= 1'b0;
			crc_w_r   <= 1'b0;
			ovr_w_r   <= 1'b0;
			miss_w_r  <= 1'b0;
			equip_w_r <= 1'b0;
			nrdy_w_r  <= 1'b0;
		end else if (state_r == DCRS_IDLE && EVT.start) begin
			// Fresh command
			eoc_w_r   <= 1'b0;
			crc_w_r   <= 1'b0;
			ovr_w_r   <= 1'b0;
			miss_w_r  <= 1'b0;
			equip_w_r <= drv_r.fault;
			nrdy_w_r  <= rw_cmd && nrdy_start;
		end else if (state_r == DCRS_EXEC) begin
			if (EVT.eoc) begin
				eoc_w_r <= 1'b1;
			end
			if (EVT.crc_fail) begin
				crc_w_r <= 1'b1;
			end
			if (ovr_evt) begin
				ovr_w_r <= 1'b1;
			end
			if (EVT.id_not_found) begin
				miss_w_r <= 1'b1;
			end
			if (drv_r.fault || retract_fail) begin
				equip_w_r <= 1'b1;
			end
		end
	end

	// Next value of the result bytes at termination
	// Events of the finishing cycle are folded in as well as the flags,
	// so a cause arriving with the end is not lost. Ready change wins
	// over every other termination code.
	always_comb begin
		tc_nxt = `DCRS_TC_NORMAL;
		if (rdy_chg) begin
			tc_nxt = `DCRS_TC_READY;
		end else if (EVT.done_bad || ovr_evt || retract_fail || nrdy_w_r || equip_w_r ||
			drv_r.fault || crc_w_r || EVT.crc_fail || miss_w_r || EVT.id_not_found) begin
			tc_nxt = `DCRS_TC_ABNORMAL;
		end
		first_nxt = `DCRS_RST_BYTE;
		first_nxt[`DCRS_F_TC_HI:`DCRS_F_TC_LO] = tc_nxt;
		first_nxt[`DCRS_F_SEEK]  = pos_cmd && (EVT.position_done || retract_fail);
		first_nxt[`DCRS_F_EQUIP] = equip_w_r || drv_r.fault || retract_fail;
		first_nxt[`DCRS_F_NRDY]  = nrdy_w_r;
		first_nxt[`DCRS_F_HEAD]  = SEL.head_side;
		first_nxt[1:0]           = SEL.unit_sel;
		second_nxt = `DCRS_RST_BYTE;
		second_nxt[`DCRS_S_EOC]  = eoc_w_r || EVT.eoc;
		second_nxt[`DCRS_S_CRC]  = crc_w_r || EVT.crc_fail;
		second_nxt[`DCRS_S_OVR]  = ovr_w_r || ovr_evt;
		second_nxt[`DCRS_S_MISS] = miss_w_r || EVT.id_not_found;
	end

	// Result byte latches, held through the result phase
	// Nothing but a termination or an undefined command loads them,
	// so the host reads steady values however slowly it polls
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			first_r  <= `DCRS_RST_BYTE;
			second_r <= `DCRS_RST_BYTE;
		end else if (state_r == DCRS_IDLE && EVT.undefined) begin
			first_r  <= `DCRS_INVALID_BYTE;
			second_r <= `DCRS_RST_BYTE;
		end else if (finish) begin
			first_r  <= first_nxt;
			second_r <= second_nxt;
		end
	end

	// Abort pulse for terminations that cut execution short
	// Ready change, overrun and failed retraction stop the sequencer at once
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			CMD_ABORT <= 1'b0;
		end else begin
			CMD_ABORT <= finish && (rdy_chg || ovr_evt || retract_fail);
		end
	end

	// Result phase flag, raised with the latched bytes
	// It falls on the edge that completes the host's read of the first byte,
	// the same edge at which the phase machine returns to idle
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			RESULT_READY <= 1'b0;
		end else begin
			RESULT_READY <= (state_r == DCRS_RESULT && !leave_res) ||
				(state_r == DCRS_IDLE && EVT.undefined) || finish;
		end
	end

	// Interrupt request level
	// A set in the same cycle as a sense query clear wins, so no cause is lost
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			INT_REQ <= 1'b0;
		end else if (finish || rdy_idle_chg) begin
			INT_REQ <= 1'b1; // Undefined command raises none
		end else if (state_r == DCRS_IDLE && EVT.start && CMD == DCRS_CMD_SENSE) begin
			INT_REQ <= 1'b0;
		end
	end

	// Control register: density select
	// Bit 0 picks the shorter double density service window;
	// a change applies from the next byte request
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			double_den_r <= 1'b0;
		end else if (apb_wr && PADDR == `DCRS_OFS_CTRL) begin
			double_den_r <= PWDATA[0];
		end
	end

	// APB read data, ready and error, registered on the setup cycle
	// Every transfer gets exactly one access cycle, with no wait states;
	// read data stand only while ready is high and are zero otherwise.
	// Unmapped addresses answer with an error and zero data.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			PRDATA  <= `DCRS_RST_WORD;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= 1'b0;
			PRDATA  <= `DCRS_RST_WORD;
			if (PSEL && !PENABLE) begin
				if (PADDR == `DCRS_OFS_FIRST) begin
					PRDATA <= {24'h000000, first_r};
				end else if (PADDR == `DCRS_OFS_SECOND) begin
					PRDATA <= {24'h000000, second_r};
				end else if (PADDR == `DCRS_OFS_CTRL) begin
					PRDATA <= {31'h00000000, double_den_r};
				end else if (PADDR == `DCRS_OFS_STATE) begin
					PRDATA <= {30'h00000000, state_r};
				end else begin
					PSLVERR <= 1'b1; // Unmapped address
				end
			end
		end
	end

endmodule

// file: testbench/dcrs_status_sva.sv
// Checker of bus timing and result phase of the status block.
// Assumes binding into dcrs_status.
`timescale 1ns/100ps
module dcrs_status_chk (
	input wire logic                CLK,
	input wire logic                NRST,
	input wire logic [11:0]         PADDR,
	input wire logic                PSEL,
	input wire logic                PENABLE,
	input wire logic                PWRITE,
	input wire logic [31:0]         PRDATA,
	input wire logic                PREADY,
	input wire logic                PSLVERR,
	input wire dcrs_pkg::dcrs_evt_t EVT,
	input wire logic                INT_REQ,
	input wire logic                RESULT_READY,
	input wire logic                CMD_ABORT
);
	import dcrs_pkg::*;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	// Setup cycle of a transfer
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	// Finished read of the first byte
	sequence s_first_rd;
		PREADY && !PWRITE && PADDR == 12'h000;
	endsequence
	chk_answer_next: assert property (s_setup |=> PREADY && PENABLE)
		else $error("no answer after setup");
	chk_answer_once: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	chk_bad_addr: assert property (PREADY && PADDR[11:4] != 8'h00
		|-> PSLVERR && PRDATA == 32'h0000_0000) else $error("unmapped not refused");
	chk_byte_low: assert property (PREADY && PADDR[11:3] == 9'h000
		|-> PRDATA[31:8] == 24'h000000) else $error("upper bits set");
	chk_unused_zero: assert property (
		PREADY && PADDR == 12'h004 |-> !PRDATA[6] && !PRDATA[3]) else $error("unused bit set");
	chk_undef_result: assert property (
		EVT.undefined && !RESULT_READY |=> RESULT_READY && !$rose(INT_REQ))
		else $error("undefined command result");
	chk_end_latch: assert property (
		(EVT.done_ok || EVT.done_bad) && !RESULT_READY |=> RESULT_READY && INT_REQ)
		else $error("end not latched");
	chk_result_hold: assert property (
		RESULT_READY && !(PREADY && !PWRITE && PADDR == 12'h000) |=> RESULT_READY)
		else $error("result phase lost");
	chk_read_leave: assert property (s_first_rd |=> !RESULT_READY)
		else $error("result phase kept");
	chk_abort_end: assert property (CMD_ABORT |-> RESULT_READY && INT_REQ)
		else $error("abort without result");
	chk_abort_once: assert property (CMD_ABORT |=> !CMD_ABORT)
		else $error("abort held");
endmodule
bind dcrs_status dcrs_status_chk u_chk (.CLK, .NRST, .PADDR, .PSEL, .PENABLE, .PWRITE,
	.PRDATA, .PREADY, .PSLVERR, .EVT, .INT_REQ, .RESULT_READY, .CMD_ABORT);

// file: testbench/dcrs_host.sv
// Host model: APB master reaching the status registers.
// Assumes the bench calls xfer from one process.
`timescale 1ns/100ps
module dcrs_host (
	input  wire logic        CLK,
	output logic [11:0]      PADDR,
	output logic             PSEL,
	output logic             PENABLE,
	output logic             PWRITE,
	output logic [31:0]      PWDATA,
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR
);
	// Idle bus at start
	initial begin
		PADDR = 12'h000;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PWDATA = 32'h0000_0000;
	end
	// Setup, then access held until ready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		PWDATA <= ~wd;
	endtask
endmodule

// file: testbench/disk_ctrl_result_status_bench.sv
// Bench: commands end, host reads both status bytes.
// Assumes host model and bound checker. Event bits: start 400 down to ack 001.
`timescale 1ns/100ps
module disk_ctrl_result_status_bench;
	import dcrs_pkg::*;
	logic        clk;
	logic        nrst;
	dcrs_cmd_t   cmd;
	dcrs_evt_t   evt;
	dcrs_sel_t   sel;
	dcrs_drv_t   drv;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        int_req;
	logic        res_rdy;
	int          error_cnt;
	int          check_count;
	int          cyc;
	dcrs_status #(.SVC_FM_CYC(20), .SVC_MFM_CYC(10)) u_dut (.CLK(clk), .NRST(nrst),
		.PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMD(cmd), .EVT(evt),
		.SEL(sel), .DRV(drv), .INT_REQ(int_req), .RESULT_READY(res_rdy), .CMD_ABORT());
	dcrs_host u_host (.CLK(clk), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic conclude();
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Read a byte register, no error expected
	task automatic rb(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic        x;
		u_host.xfer(1'b0, a, 32'h0000_0000, d, x);
		chk({x, d}, {9'h000, 16'h0000, e});
	endtask
	// One event pulse
	task automatic ev(input logic [10:0] e);
		@(posedge clk);
		evt <= dcrs_evt_t'(e);
		@(posedge clk);
		evt <= dcrs_evt_t'(11'h000);
	endtask
	// Drive lines, then let the synchroniser settle
	task automatic dset(input logic [3:0] v);
		@(posedge clk);
		drv <= dcrs_drv_t'(v);
		repeat (4) @(posedge clk);
	endtask
	task automatic wres();
		for (int n = 0; n < 200 && res_rdy !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk({32'h0, res_rdy}, 33'h1);
	endtask
	// Start, flag events high bit first, end event, read both bytes
	task automatic term(input dcrs_cmd_t c, input logic [10:0] f, input logic [10:0] x,
		input logic [7:0] e1, input logic [7:0] e2);
		@(posedge clk);
		cmd <= c;
		ev(11'h400);
		for (int i = 10; i >= 0; i--) begin
			if (f[i])
				ev(11'h001 << i);
		end
		if (x != 11'h000)
			ev(x);
		wres();
		rb(12'h004, e2);
		rb(12'h000, e1);
	endtask
	task automatic t_ends();
		term(DCRS_CMD_READ, 11'h000, 11'h200, 8'h06, 8'h00);
		term(DCRS_CMD_READ, 11'h01C, 11'h100, 8'h46, 8'hA4);
		term(DCRS_CMD_READ_ID, 11'h004, 11'h100, 8'h46, 8'h04);
		term(DCRS_CMD_READ_TRACK, 11'h004, 11'h100, 8'h46, 8'h04);
	endtask
	task automatic t_undef();
		ev(11'h080);
		wres();
		rb(12'h000, 8'h80);
	endtask
	task automatic t_drive();
		dset(4'hF);
		term(DCRS_CMD_READ, 11'h000, 11'h100, 8'h56, 8'h00);
		dset(4'h3);
		term(DCRS_CMD_READ, 11'h000, 11'h000, 8'h4E, 8'h00);
		dset(4'hA);
		term(DCRS_CMD_WRITE, 11'h000, 11'h000, 8'h4E, 8'h00);
		dset(4'hB);
		@(posedge clk);
		cmd <= DCRS_CMD_READ;
		ev(11'h400);
		dset(4'h3);
		wres();
		rb(12'h000, 8'hC6);
		dset(4'hB);
	endtask
	// Retraction: 76 steps keep running, the 77th ends it
	task automatic t_retract();
		dset(4'h9);
		@(posedge clk);
		cmd <= DCRS_CMD_RETRACT;
		ev(11'h400);
		repeat (76) ev(11'h020);
		#1;
		chk({32'h0, res_rdy}, 33'h0);
		ev(11'h020);
		wres();
		rb(12'h000, 8'h76);
		dset(4'hB);
	endtask
	// Double density window, served in time and then late
	task automatic t_overrun();
		logic [31:0] d;
		logic        x;
		u_host.xfer(1'b1, 12'h008, 32'h0000_0001, d, x);
		rb(12'h008, 8'h01);
		term(DCRS_CMD_READ, 11'h003, 11'h200, 8'h06, 8'h00);
		term(DCRS_CMD_READ, 11'h002, 11'h000, 8'h46, 8'h10);
		// Single density: a gap too long for double density is still in time
		u_host.xfer(1'b1, 12'h008, 32'h0000_0000, d, x);
		rb(12'h008, 8'h00);
		@(posedge clk);
		cmd <= DCRS_CMD_READ;
		ev(11'h400);
		ev(11'h002);
		repeat (14) @(posedge clk);
		ev(11'h201);
		wres();
		rb(12'h004, 8'h00);
		rb(12'h000, 8'h06);
		term(DCRS_CMD_READ, 11'h002, 11'h000, 8'h46, 8'h10);
		u_host.xfer(1'b0, 12'h010, 32'h0000_0000, d, x);
		chk({x, d}, 33'h1_0000_0000);
	endtask
	task automatic t_seek();
		term(DCRS_CMD_POSITION, 11'h000, 11'h040, 8'h26, 8'h00);
		chk({32'h0, int_req}, 33'h1);
		@(posedge clk);
		cmd <= DCRS_CMD_SENSE;
		ev(11'h400);
		#1;
		chk({32'h0, int_req}, 33'h0);
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		nrst = 1'b0;
		cmd = DCRS_CMD_OTHER;
		evt = dcrs_evt_t'(11'h000);
		sel = dcrs_sel_t'(3'h6);
		drv = dcrs_drv_t'(4'hB);
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_ends();
		t_undef();
		t_drive();
		t_retract();
		t_overrun();
		t_seek();
		conclude();
	end
endmodule
